// >>> inc/framer_defines.svh
// Purpose: constants of the update-status and route-record framer
// Assumes: 200 MHz clock, bytes leave most significant first
// Notes: offsets count from the start delimiter at byte 0
`ifndef FRAMER_DEFINES_SVH
`define FRAMER_DEFINES_SVH

// ==========================================================
// framing
`define SOF_BYTE      8'h7e
`define TYPE_OTA      8'ha0
`define TYPE_RR       8'ha1
`define CKSUM_BASE    8'hff
`define OFF_LEN_HI    6'd1
`define OFF_LEN_LO    6'd2
`define OFF_TYPE      6'd3
`define OTA_LEN       8'h16
`define RR_LEN_BASE   8'h0e

// ==========================================================
// update-status layout
`define OTA_OFF_SRC   6'd4
`define OTA_OFF_NWK   6'd12
`define OTA_OFF_OPT   6'd14
`define OTA_OFF_MSG   6'd15
`define OTA_OFF_BLK   6'd16
`define OTA_OFF_TGT   6'd17
`define OPT_ACK       8'h01
`define OPT_BCAST     8'h02

// ==========================================================
// route-record layout
`define RR_OFF_SRC    6'd5
`define RR_OFF_NWK    6'd13
`define RR_OFF_OPT    6'd15
`define RR_OFF_CNT    6'd16
`define RR_OFF_HOP    6'd17
`define RR_MAX_HOPS   8
`define RR_TBL_SIZE   4
`define LOWMEM_BIT    6

// ==========================================================
// timing and buffering
`define CLK_HZ        64'd200000000
`define NACK_QUIET_S  64'd75
`define NACK_QUIET_CYC (`NACK_QUIET_S * `CLK_HZ)
`define FIFO_DEPTH    16
`define FIFO_WIDTH    8

`endif

// >>> inc/framer_pkg.sv
// Purpose: types shared by the framer and its testbench
// Assumes: constants come from framer_defines.svh
// Notes: struct holds one captured frame request
`include "framer_defines.svh"

package framer_pkg;
	typedef enum logic [7:0] {
		MSG_ACK    = 8'h06,
		MSG_NACK   = 8'h15,
		MSG_NOMAC  = 8'h40,
		MSG_QUERY  = 8'h51,
		MSG_QRESP  = 8'h52
	} loader_msg_e;

	typedef enum logic {
		KIND_OTA = 1'b0,
		KIND_RR  = 1'b1
	} frame_kind_e;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_EMIT = 2'b10
	} framer_state_e;

	typedef struct packed {
		frame_kind_e                       kind;
		logic [63:0]                       src64;
		logic [15:0]                       nwk16;
		logic [7:0]                        opts;
		loader_msg_e                       msg;
		logic [7:0]                        blk;
		logic [63:0]                       tgt64;
		logic [3:0]                        nhops;
		logic [`RR_MAX_HOPS-1:0][15:0]     hops;
	} frame_s;
endpackage

// >>> inc/fifo_if.sv
// Purpose: valid/ready byte channel between framer parts
// Assumes: transfer when valid and ready are both high
// Notes: prod drives data, cons drives ready
`timescale 1ns/100ps

interface fifo_if #(parameter int WIDTH = 8);
	logic             valid;
	logic             ready;
	logic [WIDTH-1:0] data;

	modport prod (output valid, output data, input ready);
	modport cons (input valid, input data, output ready);
endinterface

// >>> design/byte_fifo.sv
// Purpose: flip-flop FIFO with valid/ready on both sides
// Assumes: depth is a power of two
// Notes: ready and valid drop while ce_in is low
`timescale 1ns/100ps

module byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	// clock, reset, enable
	input  wire logic clk_in,
	input  wire logic rstn_in,
	input  wire logic ce_in,
	// fill and drain sides
	fifo_if.cons      wr,
	fifo_if.prod      rd
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [WIDTH-1:0] mem_d [DEPTH];
	logic [AW-1:0]    wptr_q, wptr_d;
	logic [AW-1:0]    rptr_q, rptr_d;
	logic [AW:0]      cnt_q, cnt_d;
	logic             wr_fire;
	logic             rd_fire;

	// ==========================================================
	// handshakes
	assign wr.ready = ce_in && (cnt_q != (AW+1)'(DEPTH));
	assign rd.valid = ce_in && (cnt_q != '0);
	assign rd.data  = mem_q[rptr_q];
	assign wr_fire  = wr.valid && wr.ready;
	assign rd_fire  = rd.valid && rd.ready;

	// ==========================================================
	// storage
	genvar i;
	generate
		for (i = 0; i < DEPTH; i++)
		begin : g_ent
			always_comb
			begin
				mem_d[i] = mem_q[i];
				if (wr_fire && wptr_q == AW'(i))
					mem_d[i] = wr.data;
			end
			always_ff @(posedge clk_in or negedge rstn_in)
			begin
				if (!rstn_in)
					mem_q[i] <= '0;
				else if (ce_in)
					mem_q[i] <= mem_d[i];
			end
		end
	endgenerate

	// ==========================================================
	// pointers
	always_comb
	begin
		wptr_d = wr_fire ? wptr_q + AW'(1) : wptr_q;
		rptr_d = rd_fire ? rptr_q + AW'(1) : rptr_q;
		cnt_d  = cnt_q;
		if (wr_fire && !rd_fire)
			cnt_d = cnt_q + (AW+1)'(1);
		else if (rd_fire && !wr_fire)
			cnt_d = cnt_q - (AW+1)'(1);
	end

	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			wptr_q <= '0;
			rptr_q <= '0;
			cnt_q  <= '0;
		end
		else if (ce_in)
		begin
			wptr_q <= wptr_d;
			rptr_q <= rptr_d;
			cnt_q  <= cnt_d;
		end
	end

	a_fifo_bound: assert property (@(posedge clk_in) disable iff (!rstn_in)
		cnt_q <= (AW+1)'(DEPTH)) else $error("fifo count past depth");
	a_fifo_fill: assert property (@(posedge clk_in) disable iff (!rstn_in)
		wr_fire && !rd_fire |=> cnt_q == $past(cnt_q) + (AW+1)'(1)) else $error("fifo count missed a write");
endmodule

// >>> design/ota_status_route_record_framer.sv
// Purpose: builds update-status and route-record frames for the host
// Assumes: requests synchronous to clk_in; host drains tx stream
// Notes: one frame in flight; bytes leave through a 16-byte fifo
`timescale 1ns/100ps
`include "framer_defines.svh"

module ota_status_route_record_framer #(
	parameter longint unsigned NACK_QUIET_CYCLES = `NACK_QUIET_CYC
) (
	// clock, reset, enable
	input  wire logic                            clk_in,
	input  wire logic                            rstn_in,
	input  wire logic                            ce_in,
	// device options setting
	input  wire logic [7:0]                      dev_opts_in,
	// update-status request
	input  wire logic                            ota_valid_in,
	output logic                                 ota_ready_out,
	input  wire logic [63:0]                     ota_remote_in,
	input  wire logic [15:0]                     ota_updater_in,
	input  wire logic                            ota_bcast_in,
	input  framer_pkg::loader_msg_e              ota_msg_in,
	input  wire logic                            ota_blk_valid_in,
	input  wire logic [7:0]                      ota_blk_in,
	input  wire logic [63:0]                     ota_target_in,
	// route record event
	input  wire logic                            rr_valid_in,
	output logic                                 rr_ready_out,
	input  wire logic [63:0]                     rr_src64_in,
	input  wire logic [15:0]                     rr_src16_in,
	input  wire logic                            rr_acked_in,
	input  wire logic                            rr_bcast_in,
	input  wire logic [3:0]                      rr_hops_in,
	input  wire logic [`RR_MAX_HOPS-1:0][15:0]   rr_hop_addr_in,
	// route failure
	input  wire logic                            rt_fail_in,
	input  wire logic [63:0]                     rt_fail_addr_in,
	// update target quiet timer
	input  wire logic                            nack_sent_in,
	input  wire logic                            msg_rx_in,
	output logic                                 query_accept_out,
	// byte stream to host
	output logic                                 tx_valid_out,
	output logic [7:0]                           tx_data_out,
	input  wire logic                            tx_ready_in
);
	framer_pkg::framer_state_e st_q, st_d;
	framer_pkg::frame_s        f_q, f_d;
	logic [5:0]                idx_q, idx_d;
	logic [7:0]                sum_q, sum_d;
	logic [7:0]                len, cur;
	logic [5:0]                last, rel;
	logic                      push_fire, low_mem, rr_take, rr_emit, hit;
	logic [`RR_TBL_SIZE-1:0]   hit_v, fail_v;
	logic [`RR_TBL_SIZE-1:0]   vld_q, vld_d;
	logic [63:0]               tad_q [`RR_TBL_SIZE];
	logic [63:0]               tad_d [`RR_TBL_SIZE];
	logic [1:0]                tptr_q, tptr_d;
	logic                      busy_q, busy_d;
	logic [35:0]               qcnt_q, qcnt_d;

	fifo_if #(.WIDTH(`FIFO_WIDTH)) push_if ();
	fifo_if #(.WIDTH(`FIFO_WIDTH)) pop_if ();

	// ==========================================================
	// request handshakes
	assign low_mem       = dev_opts_in[`LOWMEM_BIT];
	assign ota_ready_out = ce_in && st_q == framer_pkg::ST_IDLE;
	// update-status wins a tie; the event waits one frame
	assign rr_ready_out  = ota_ready_out && !ota_valid_in;
	assign rr_take       = rr_valid_in && rr_ready_out;
	assign rr_emit       = low_mem || (!rr_bcast_in && !hit);
	assign push_fire     = push_if.valid && push_if.ready;

	// ==========================================================
	// known-source table
	genvar i;
	generate
		for (i = 0; i < `RR_TBL_SIZE; i++)
		begin : g_tbl
			assign hit_v[i]  = vld_q[i] && tad_q[i] == rr_src64_in;
			assign fail_v[i] = rt_fail_in && vld_q[i] && tad_q[i] == rt_fail_addr_in;
		end
	endgenerate
	assign hit = |hit_v;

	always_comb
	begin
		// a failed route forgets the source so its next unicast reports
		vld_d  = vld_q & ~fail_v;
		tad_d  = tad_q;
		tptr_d = tptr_q;
		if (rr_take && !low_mem && !rr_bcast_in && !hit)
		begin
			vld_d[tptr_q] = 1'b1;
			tad_d[tptr_q] = rr_src64_in;
			tptr_d        = tptr_q + 2'd1;
		end
	end

	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			vld_q  <= '0;
			tad_q  <= '{default: 64'h0};
			tptr_q <= 2'd0;
		end
		else if (ce_in)
		begin
			vld_q  <= vld_d;
			tad_q  <= tad_d;
			tptr_q <= tptr_d;
		end
	end

	// ==========================================================
	// frame sequencer
	always_comb
	begin
		st_d  = st_q;
		f_d   = f_q;
		idx_d = idx_q;
		sum_d = sum_q;
		case (st_q)
			framer_pkg::ST_IDLE:
			begin
				if (ota_valid_in && ota_ready_out)
				begin
					f_d.kind  = framer_pkg::KIND_OTA;
					f_d.src64 = ota_remote_in;
					f_d.nwk16 = ota_updater_in;
					f_d.opts  = ota_bcast_in ? `OPT_BCAST : `OPT_ACK;
					f_d.msg   = ota_msg_in;
					f_d.blk   = ota_blk_valid_in ? ota_blk_in : 8'h00;
					f_d.tgt64 = ota_target_in;
					st_d      = framer_pkg::ST_EMIT;
					idx_d     = 6'd0;
					sum_d     = 8'h00;
				end
				else if (rr_take && rr_emit)
				begin
					f_d.kind  = framer_pkg::KIND_RR;
					f_d.src64 = rr_src64_in;
					f_d.nwk16 = rr_src16_in;
					f_d.opts  = {6'h00, rr_bcast_in, rr_acked_in};
					// longer routes are cut to the hop store
					f_d.nhops = (rr_hops_in > 4'(`RR_MAX_HOPS)) ? 4'(`RR_MAX_HOPS) : rr_hops_in;
					f_d.hops  = rr_hop_addr_in;
					st_d      = framer_pkg::ST_EMIT;
					idx_d     = 6'd0;
					sum_d     = 8'h00;
				end
			end
			framer_pkg::ST_EMIT:
			begin
				if (push_fire)
				begin
					idx_d = idx_q + 6'd1;
					if (idx_q >= `OFF_TYPE)
						sum_d = sum_q + cur;
					if (idx_q == last)
						st_d = framer_pkg::ST_IDLE;
				end
			end
			default:
				st_d = framer_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			st_q  <= framer_pkg::ST_IDLE;
			f_q   <= '0;
			idx_q <= 6'd0;
			sum_q <= 8'h00;
		end
		else if (ce_in)
		begin
			st_q  <= st_d;
			f_q   <= f_d;
			idx_q <= idx_d;
			sum_q <= sum_d;
		end
	end

	// ==========================================================
	// byte selection
	always_comb
	begin
		len  = (f_q.kind == framer_pkg::KIND_OTA) ? `OTA_LEN
		     : `RR_LEN_BASE + {3'd0, f_q.nhops, 1'b0};
		last = len[5:0] + `OFF_TYPE;
		cur  = 8'h00;
		rel  = 6'd0;
		if (idx_q == 6'd0)
			cur = `SOF_BYTE;
		else if (idx_q == `OFF_LEN_HI)
			cur = 8'h00;
		else if (idx_q == `OFF_LEN_LO)
			cur = len;
		else if (idx_q == last)
			cur = `CKSUM_BASE - sum_q;
		else if (f_q.kind == framer_pkg::KIND_OTA)
		begin
			if (idx_q == `OFF_TYPE)
				cur = `TYPE_OTA;
			else if (idx_q < `OTA_OFF_NWK)
			begin
				rel = idx_q - `OTA_OFF_SRC;
				cur = f_q.src64[8*(7-rel[2:0]) +: 8];
			end
			else if (idx_q < `OTA_OFF_OPT)
				cur = (idx_q == `OTA_OFF_NWK) ? f_q.nwk16[15:8] : f_q.nwk16[7:0];
			else if (idx_q == `OTA_OFF_OPT)
				cur = f_q.opts;
			else if (idx_q == `OTA_OFF_MSG)
				cur = f_q.msg;
			else if (idx_q == `OTA_OFF_BLK)
				cur = f_q.blk;
			else
			begin
				rel = idx_q - `OTA_OFF_TGT;
				cur = f_q.tgt64[8*(7-rel[2:0]) +: 8];
			end
		end
		else
		begin
			// byte 4 of this frame is a spare zero
			if (idx_q == `OFF_TYPE)
				cur = `TYPE_RR;
			else if (idx_q >= `RR_OFF_SRC && idx_q < `RR_OFF_NWK)
			begin
				rel = idx_q - `RR_OFF_SRC;
				cur = f_q.src64[8*(7-rel[2:0]) +: 8];
			end
			else if (idx_q >= `RR_OFF_NWK && idx_q < `RR_OFF_OPT)
				cur = (idx_q == `RR_OFF_NWK) ? f_q.nwk16[15:8] : f_q.nwk16[7:0];
			else if (idx_q == `RR_OFF_OPT)
				cur = f_q.opts;
			else if (idx_q == `RR_OFF_CNT)
				cur = {4'h0, f_q.nhops};
			else if (idx_q >= `RR_OFF_HOP)
			begin
				// entry 0 is the hop next to the destination
				rel = idx_q - `RR_OFF_HOP;
				cur = rel[0] ? f_q.hops[rel[3:1]][7:0] : f_q.hops[rel[3:1]][15:8];
			end
		end
	end

	assign push_if.valid = st_q == framer_pkg::ST_EMIT;
	assign push_if.data  = cur;

	// ==========================================================
	// output buffer
	byte_fifo #(.WIDTH(`FIFO_WIDTH), .DEPTH(`FIFO_DEPTH)) u_fifo (
		.clk_in  (clk_in),
		.rstn_in (rstn_in),
		.ce_in   (ce_in),
		.wr      (push_if),
		.rd      (pop_if)
	);

	assign tx_valid_out = pop_if.valid;
	assign tx_data_out  = pop_if.data;
	assign pop_if.ready = tx_ready_in;

	// ==========================================================
	// update target quiet timer
	always_comb
	begin
		busy_d = busy_q;
		qcnt_d = qcnt_q + 36'd1;
		if (nack_sent_in)
		begin
			busy_d = 1'b1;
			qcnt_d = 36'd0;
		end
		else if (msg_rx_in || !busy_q)
			qcnt_d = 36'd0;
		else if (qcnt_q == 36'(NACK_QUIET_CYCLES - 1))
		begin
			busy_d = 1'b0;
			qcnt_d = 36'd0;
		end
	end

	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			busy_q <= 1'b0;
			qcnt_q <= 36'd0;
		end
		else if (ce_in)
		begin
			busy_q <= busy_d;
			qcnt_q <= qcnt_d;
		end
	end

	assign query_accept_out = !busy_q;

	// ==========================================================
	// checks
	a_sof_len: assert property (@(posedge clk_in) disable iff (!rstn_in)
		push_fire && idx_q == 6'd0 |=> push_if.data == 8'h00 && idx_q == 6'd1)
		else $error("length high byte missing after delimiter");
	a_type_ota: assert property (@(posedge clk_in) disable iff (!rstn_in)
		push_fire && idx_q == `OFF_TYPE && f_q.kind == framer_pkg::KIND_OTA |-> push_if.data == 8'ha0)
		else $error("update-status type code wrong");
	a_type_rr: assert property (@(posedge clk_in) disable iff (!rstn_in)
		push_fire && idx_q == `OFF_TYPE && f_q.kind == framer_pkg::KIND_RR |-> push_if.data == 8'ha1)
		else $error("route-record type code wrong");
	a_ota_opts: assert property (@(posedge clk_in) disable iff (!rstn_in)
		ota_valid_in && ota_ready_out |=> f_q.opts == ($past(ota_bcast_in) ? 8'h02 : 8'h01))
		else $error("update-status options byte invalid");
	a_rr_count: assert property (@(posedge clk_in) disable iff (!rstn_in)
		push_fire && idx_q == 6'd16 && f_q.kind == framer_pkg::KIND_RR
		|-> push_if.data <= 8'h08 && len == 8'h0e + 2 * push_if.data)
		else $error("hop count and length disagree");
	a_cksum_end: assert property (@(posedge clk_in) disable iff (!rstn_in)
		push_fire && idx_q == last |-> push_if.data + sum_q == 8'hff ##1 st_q == framer_pkg::ST_IDLE)
		else $error("checksum byte or frame end wrong");
	a_lowmem_emit: assert property (@(posedge clk_in) disable iff (!rstn_in)
		rr_take && dev_opts_in[6] |=> st_q == framer_pkg::ST_EMIT && f_q.src64 == $past(rr_src64_in))
		else $error("low-memory event not reported");
	a_himem_skip: assert property (@(posedge clk_in) disable iff (!rstn_in)
		rr_take && !dev_opts_in[6] && hit |=> st_q == framer_pkg::ST_IDLE)
		else $error("known source reported again");
	a_nack_quiet: assert property (@(posedge clk_in) disable iff (!rstn_in)
		$fell(busy_q) |-> $past(qcnt_q) == 36'(NACK_QUIET_CYCLES - 1) && !$past(msg_rx_in))
		else $error("target freed before quiet time");
endmodule

// >>> tb/host_model.sv
// Purpose: host side that drains the framer byte stream
// Assumes: mode 0 prompt, 1 every other cycle, 2 stalled
// Notes: bad checksum frames are dropped, good ones land in rx_q
`timescale 1ns/100ps

module host_model (
	// clock and reset
	input  wire logic       clk_in,
	input  wire logic       rstn_in,
	// byte stream from the framer
	input  wire logic       tx_valid_in,
	input  wire logic [7:0] tx_data_in,
	output logic            tx_ready_out,
	// pacing
	input  wire logic [1:0] mode_in
);
	logic [7:0] cur_q[$];
	logic [7:0] rx_q[$];
	logic [7:0] sum;
	int         bad_cnt = 0;

	// ==========================================================
	// pacing, slow mode toggles so the fifo sees stalls mid frame
	always @(posedge clk_in or negedge rstn_in)
		if (!rstn_in)
			tx_ready_out <= 1'b0;
		else
			tx_ready_out <= (mode_in == 2'd0) || (mode_in == 2'd1 && !tx_ready_out);

	// ==========================================================
	// frame collection, resyncs on the start byte
	always @(posedge clk_in)
		if (rstn_in && tx_valid_in && tx_ready_out)
		begin
			cur_q.push_back(tx_data_in);
			if (cur_q[0] !== 8'h7e)
				cur_q.delete();
			else if (cur_q.size() > 3 && cur_q.size() == {cur_q[1], cur_q[2]} + 4)
			begin
				sum = 8'h00;
				for (int i = 3; i < cur_q.size(); i++)
					sum = sum + cur_q[i];
				if (sum === 8'hff)
					rx_q = {rx_q, cur_q};
				else
					bad_cnt++;
				cur_q.delete();
			end
		end
endmodule

// >>> tb/tb_top.sv
// Purpose: self-checking bench for the update-status and route-record framer
// Assumes: quiet timer shortened to 50 cycles
// Notes: expected frames are rebuilt here byte by byte
`timescale 1ns/100ps
`include "framer_defines.svh"
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin num_errors++; $display("Error %s expected %h seen %h", nm, e, g); end end

module tb_top;
	logic                          clk_in, rstn_in, ce_in, ota_valid_in, ota_bcast_in, ota_blk_valid_in;
	logic [7:0]                    dev_opts_in, ota_blk_in, tx_data_out;
	logic [63:0]                   ota_remote_in, ota_target_in, rr_src64_in, rt_fail_addr_in;
	logic [15:0]                   ota_updater_in, rr_src16_in;
	framer_pkg::loader_msg_e       ota_msg_in;
	logic                          rr_valid_in, rr_acked_in, rr_bcast_in, rt_fail_in, nack_sent_in, msg_rx_in;
	logic [3:0]                    rr_hops_in;
	logic [`RR_MAX_HOPS-1:0][15:0] rr_hop_addr_in;
	logic                          ota_ready_out, rr_ready_out, query_accept_out, tx_valid_out, tx_ready_in;
	logic [1:0]                    host_mode;
	logic [7:0]                    exp_q[$];
	int                            num_errors = 0;
	int                            check_count = 0;

	ota_status_route_record_framer #(.NACK_QUIET_CYCLES(50)) u_ota_status_route_record_framer (
		.clk_in(clk_in), .rstn_in(rstn_in), .ce_in(ce_in), .dev_opts_in(dev_opts_in),
		.ota_valid_in(ota_valid_in), .ota_ready_out(ota_ready_out), .ota_remote_in(ota_remote_in),
		.ota_updater_in(ota_updater_in), .ota_bcast_in(ota_bcast_in), .ota_msg_in(ota_msg_in),
		.ota_blk_valid_in(ota_blk_valid_in), .ota_blk_in(ota_blk_in), .ota_target_in(ota_target_in),
		.rr_valid_in(rr_valid_in), .rr_ready_out(rr_ready_out), .rr_src64_in(rr_src64_in),
		.rr_src16_in(rr_src16_in), .rr_acked_in(rr_acked_in), .rr_bcast_in(rr_bcast_in),
		.rr_hops_in(rr_hops_in), .rr_hop_addr_in(rr_hop_addr_in), .rt_fail_in(rt_fail_in),
		.rt_fail_addr_in(rt_fail_addr_in), .nack_sent_in(nack_sent_in), .msg_rx_in(msg_rx_in),
		.query_accept_out(query_accept_out), .tx_valid_out(tx_valid_out), .tx_data_out(tx_data_out),
		.tx_ready_in(tx_ready_in));

	host_model u_host_model (.clk_in(clk_in), .rstn_in(rstn_in), .tx_valid_in(tx_valid_out),
		.tx_data_in(tx_data_out), .tx_ready_out(tx_ready_in), .mode_in(host_mode));

	// ==========================================================
	// clock and watchdog, budget is well above the ~800 cycles used
	initial
	begin
		clk_in = 1'b0;
		forever #2.5 clk_in = ~clk_in;
	end

	initial
	begin
		repeat (20000) @(posedge clk_in);
		num_errors++;
		print_verdict();
	end

	// ==========================================================
	// helpers
	task automatic print_verdict();
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic put(inout logic [7:0] b[$], input logic [63:0] v, input int n);
		for (int i = n - 1; i >= 0; i--)
			b.push_back(v[8*i +: 8]);
	endtask

	// wraps frame data with start byte, length and checksum
	task automatic seal(input logic [7:0] b[$]);
		logic [7:0] s;
		s = 8'h00;
		foreach (b[i])
			s = s + b[i];
		exp_q = {8'h7e, 8'h00, 8'(b.size())};
		exp_q = {exp_q, b, 8'hff - s};
	endtask

	task automatic get_frame(input string nm);
		int n;
		n = 0;
		while (u_host_model.rx_q.size() < exp_q.size() && n < 3000)
		begin
			@(posedge clk_in);
			n++;
		end
		`CHK({nm, " size"}, exp_q.size(), u_host_model.rx_q.size())
		foreach (exp_q[i])
			`CHK(nm, exp_q[i], u_host_model.rx_q[i])
		u_host_model.rx_q.delete();
	endtask

	task automatic no_frame(input string nm);
		repeat (80) @(posedge clk_in);
		`CHK(nm, 0, u_host_model.rx_q.size())
	endtask

	task automatic send_ota(input framer_pkg::loader_msg_e m, input logic bc, input logic bv, input logic [7:0] bk);
		logic [7:0] b[$];
		@(posedge clk_in);
		ota_valid_in     <= 1'b1;
		ota_msg_in       <= m;
		ota_bcast_in     <= bc;
		ota_blk_valid_in <= bv;
		ota_blk_in       <= bk;
		@(negedge clk_in);
		while (ota_ready_out !== 1'b1)
			@(negedge clk_in);
		`CHK("rr yields to update", 1'b0, rr_ready_out)
		@(posedge clk_in);
		ota_valid_in <= 1'b0;
		b = {8'ha0};
		put(b, ota_remote_in, 8);
		put(b, 64'(ota_updater_in), 2);
		b.push_back(bc ? 8'h02 : 8'h01);
		b.push_back(m);
		b.push_back(bv ? bk : 8'h00);
		put(b, ota_target_in, 8);
		seal(b);
	endtask

	task automatic send_rr(input logic [63:0] s, input logic ak, input logic bc, input logic [3:0] h);
		logic [7:0] b[$];
		int         n;
		// counts above the hop store are cut to eight
		n = (h > 4'd8) ? 8 : h;
		@(posedge clk_in);
		rr_valid_in <= 1'b1;
		rr_src64_in <= s;
		rr_acked_in <= ak;
		rr_bcast_in <= bc;
		rr_hops_in  <= h;
		@(negedge clk_in);
		while (rr_ready_out !== 1'b1)
			@(negedge clk_in);
		@(posedge clk_in);
		rr_valid_in <= 1'b0;
		b = {8'ha1, 8'h00};
		put(b, s, 8);
		put(b, 64'(rr_src16_in), 2);
		b.push_back({6'h00, bc, ak});
		b.push_back(8'(n));
		for (int i = 0; i < n; i++)
			put(b, 64'(rr_hop_addr_in[i]), 2);
		seal(b);
	endtask

	// ==========================================================
	// scenarios
	task automatic t_ota_codes();
		framer_pkg::loader_msg_e m;
		m = m.first();
		for (int k = 0; k < 5; k++)
		begin
			send_ota(m, k[0], k[1], 8'(8'h30 + k));
			get_frame("update frame");
			m = m.next();
		end
	endtask

	// 26 bytes cannot fit the 16 word fifo, so the framer must stall
	task automatic t_fill();
		@(posedge clk_in);
		host_mode <= 2'd2;
		send_ota(framer_pkg::MSG_NACK, 1'b0, 1'b1, 8'h00);
		repeat (40) @(posedge clk_in);
		@(negedge clk_in);
		`CHK("valid while stalled", 1'b1, tx_valid_out)
		`CHK("ready while stalled", 1'b0, ota_ready_out)
		`CHK("rr ready while stalled", 1'b0, rr_ready_out)
		@(posedge clk_in);
		ce_in <= 1'b0;
		@(negedge clk_in);
		`CHK("valid with ce low", 1'b0, tx_valid_out)
		@(posedge clk_in);
		ce_in     <= 1'b1;
		host_mode <= 2'd0;
		get_frame("stalled frame");
	endtask

	task automatic t_rr_low();
		@(posedge clk_in);
		dev_opts_in <= 8'h40;
		host_mode   <= 2'd1;
		send_rr(64'h0013_0000_1234_5678, 1'b1, 1'b0, 4'd3);
		get_frame("route 3 hops");
		send_rr(64'h0013_0000_1234_5678, 1'b1, 1'b0, 4'd0);
		get_frame("route 0 hops");
		send_rr(64'h0013_0000_1234_5678, 1'b0, 1'b1, 4'd8);
		get_frame("route 8 hops");
		send_rr(64'h0013_0000_1234_5678, 1'b1, 1'b1, 4'd11);
		get_frame("route clamped");
		host_mode <= 2'd0;
	endtask

	task automatic t_rr_high();
		@(posedge clk_in);
		dev_opts_in <= 8'h00;
		send_rr(64'h0000_00aa_0000_0001, 1'b1, 1'b0, 4'd2);
		get_frame("first unicast");
		send_rr(64'h0000_00aa_0000_0001, 1'b1, 1'b0, 4'd2);
		no_frame("repeat unicast");
		send_rr(64'h0000_00aa_0000_0002, 1'b0, 1'b1, 4'd1);
		no_frame("broadcast");
		@(posedge clk_in);
		rt_fail_in      <= 1'b1;
		rt_fail_addr_in <= 64'h0000_00aa_0000_0001;
		@(posedge clk_in);
		rt_fail_in <= 1'b0;
		send_rr(64'h0000_00aa_0000_0001, 1'b1, 1'b0, 4'd2);
		get_frame("after failure");
	endtask

	task automatic t_nack();
		@(posedge clk_in);
		nack_sent_in <= 1'b1;
		@(posedge clk_in);
		nack_sent_in <= 1'b0;
		@(negedge clk_in);
		`CHK("accept after nack", 1'b0, query_accept_out)
		repeat (30) @(posedge clk_in);
		msg_rx_in <= 1'b1;
		@(posedge clk_in);
		msg_rx_in <= 1'b0;
		repeat (45) @(posedge clk_in);
		@(negedge clk_in);
		`CHK("accept after restart", 1'b0, query_accept_out)
		repeat (15) @(posedge clk_in);
		@(negedge clk_in);
		`CHK("accept after quiet", 1'b1, query_accept_out)
	endtask

	// ==========================================================
	// main sequence
	initial
	begin
		rstn_in = 1'b0;
		ce_in = 1'b1;
		dev_opts_in = 8'h00;
		host_mode = 2'd0;
		ota_valid_in = 1'b0;
		ota_remote_in = 64'h0102_0304_0506_0708;
		ota_updater_in = 16'hbeef;
		ota_target_in = 64'h1112_1314_1516_1718;
		ota_bcast_in = 1'b0;
		ota_msg_in = framer_pkg::MSG_ACK;
		ota_blk_valid_in = 1'b0;
		ota_blk_in = 8'h00;
		rr_valid_in = 1'b0;
		rr_src64_in = 64'h0;
		rr_src16_in = 16'hdddd;
		rr_acked_in = 1'b0;
		rr_bcast_in = 1'b0;
		rr_hops_in = 4'd0;
		rr_hop_addr_in = {16'h8888, 16'h7777, 16'h6666, 16'h5555, 16'h4444, 16'haaaa, 16'hbbbb, 16'hcccc};
		rt_fail_in = 1'b0;
		rt_fail_addr_in = 64'h0;
		nack_sent_in = 1'b0;
		msg_rx_in = 1'b0;
		repeat (2) @(posedge clk_in);
		rstn_in <= 1'b1;
		@(negedge clk_in);
		`CHK("accept at reset", 1'b1, query_accept_out)
		`CHK("valid at reset", 1'b0, tx_valid_out)
		t_ota_codes();
		t_fill();
		t_rr_low();
		t_rr_high();
		t_nack();
		`CHK("bad frames", 0, u_host_model.bad_cnt)
		print_verdict();
	end
endmodule
